// ---- core/pdm_mapper.sv ----
// Program/data space mapper: table reads, program window, X/Y steering, APB registers.
// Assumes memories whose read data follows their registered address in the same cycle.
`timescale 1ns/1ps
module pdm_mapper
   import pdm_pkg::*;
#(
   parameter logic [15:0] YBASE_RESET = PDM_YBASE_RST,
   parameter logic [15:0] YEND_RESET = PDM_YEND_RST,
   parameter logic [15:0] RAMEND_RESET = PDM_RAMEND_RST
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PDM_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pc_step,
   input wire logic pc_load,
   input wire logic [22:0] pc_load_value,
   output logic [22:0] pc,
   input wire logic req_valid,
   input wire pdm_kind_t req_kind,
   input wire pdm_ptr_t req_ptr,
   input wire logic [15:0] req_ea,
   input wire logic req_byte,
   input wire logic req_mac,
   input wire logic req_move,
   input wire logic req_bitrev,
   input wire logic req_modulo,
   input wire logic [15:0] req_wdata,
   input wire logic table_busy,
   input wire logic rep_active,
   input wire logic rep_first,
   input wire logic rep_last,
   input wire logic rep_irq_exit,
   input wire logic rep_irq_reentry,
   output logic [23:0] pm_addr,
   output logic pm_rd,
   input wire logic [23:0] pm_rdata,
   output logic [15:0] x_addr,
   output logic x_rd,
   output logic x_wr,
   output logic x_byte,
   output logic [15:0] x_wdata,
   input wire logic [15:0] x_rdata,
   output logic [15:0] y_addr,
   output logic y_rd,
   input wire logic [15:0] y_rdata,
   output logic bitrev_en,
   output logic modulo_en,
   output logic [1:0] extra_cycles,
   output logic [15:0] rd_data,
   output logic [15:0] y_rd_data,
   output logic rd_valid
);

   logic [22:0] pc_r;
   logic core_control_register_r;
   logic [7:0] program_window_page_r;
   logic [7:0] table_page_r;
   logic [15:0] y_base_r;
   logic [15:0] y_end_r;
   logic [15:0] ram_end_r;
   logic [15:0] window_count_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] rdmux;
   logic rd_hit;
   logic apb_wr;

   logic table_op;
   logic is_read;
   logic is_write;
   logic win_hit;
   logic in_y;
   logic y_fetch;
   logic wrong_space;
   logic unimpl;
   logic [1:0] cost;
   pdm_src_t src_nxt;

   pdm_src_t src_r;
   pdm_src_t ysrc_r;
   logic sel_r;
   logic byte_r;
   logic [23:0] pm_addr_r;
   logic pm_rd_r;
   logic [15:0] x_addr_r;
   logic x_rd_r;
   logic x_wr_r;
   logic x_byte_r;
   logic [15:0] x_wdata_r;
   logic [15:0] y_addr_r;
   logic y_rd_r;
   logic bitrev_en_r;
   logic modulo_en_r;
   logic [1:0] extra_cycles_r;
   logic [15:0] rd_data_r;
   logic [15:0] y_rd_data_r;
   logic rd_valid_r;
   logic last_win_r;
   logic last_zero_r;

   // In byte mode, places the addressed byte in the low lane with the upper lane zero; a word passes unchanged.
   function automatic logic [15:0] pick_byte(input logic [15:0] w, input logic sel, input logic bmode);
      logic [15:0] r;
      r = w;
      if (bmode) begin
         r = sel ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
      end
      return r;
   endfunction : pick_byte

   // ---------------- Program counter ----------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pc_r <= 23'h000000;
      end else if (pc_load) begin
         pc_r <= {pc_load_value[22:1], 1'b0};
      end else if (pc_step) begin
         pc_r <= pc_r + PDM_PC_STEP;
      end
   end

   // ---------------- APB slave ----------------
   // The answer is prepared in the setup cycle, so every access phase ends after one cycle.
   always_comb begin
      rdmux = 32'h00000000;
      rd_hit = 1'b1;
      case (paddr)
         PDM_OFF_CTRL: rdmux[PDM_CTRL_WIN_BIT] = core_control_register_r;
         PDM_OFF_WPAGE: rdmux[7:0] = program_window_page_r;
         PDM_OFF_TPAGE: rdmux[7:0] = table_page_r;
         PDM_OFF_YBASE: rdmux[15:0] = y_base_r;
         PDM_OFF_YEND: rdmux[15:0] = y_end_r;
         PDM_OFF_RAMEND: rdmux[15:0] = ram_end_r;
         PDM_OFF_STATUS: rdmux[3:0] = {last_zero_r, last_win_r, extra_cycles_r};
         PDM_OFF_WINCNT: rdmux[15:0] = window_count_r;
         default: rd_hit = 1'b0;
      endcase
   end

   assign apb_wr = psel && penable && pready_r && pwrite && rd_hit;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= psel && !penable;
         pslverr_r <= psel && !penable && !rd_hit;
         prdata_r <= (psel && !penable && !pwrite) ? rdmux : 32'h00000000;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         core_control_register_r <= 1'b0;
         program_window_page_r <= 8'h00;
         table_page_r <= 8'h00;
         y_base_r <= YBASE_RESET;
         y_end_r <= YEND_RESET;
         ram_end_r <= RAMEND_RESET;
      end else if (apb_wr) begin
         case (paddr)
            PDM_OFF_CTRL: core_control_register_r <= pwdata[PDM_CTRL_WIN_BIT];
            PDM_OFF_WPAGE: program_window_page_r <= pwdata[7:0];
            PDM_OFF_TPAGE: table_page_r <= pwdata[7:0];
            PDM_OFF_YBASE: y_base_r <= pwdata[15:0];
            PDM_OFF_YEND: y_end_r <= pwdata[15:0];
            PDM_OFF_RAMEND: ram_end_r <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ---------------- Request decode ----------------
   always_comb begin
      table_op = (req_kind != PDM_K_DATA_RD) && (req_kind != PDM_K_DATA_WR);
      is_read = req_valid && (req_kind == PDM_K_DATA_RD);
      is_write = req_valid && (req_kind == PDM_K_DATA_WR);
      // Table traffic, in flight or starting now, hides the window.
      win_hit = req_ea[15] && core_control_register_r && !table_op && !table_busy;
      in_y = (req_ea >= y_base_r) && (req_ea <= y_end_r);
      y_fetch = req_mac && ((req_ptr == PDM_P_Y_POINTER_A) || (req_ptr == PDM_P_Y_POINTER_B));
      // X pointers must not reach Y, Y pointers must stay in Y; others see one linear space.
      wrong_space = req_mac && (((req_ptr == PDM_P_X_POINTER_A || req_ptr == PDM_P_X_POINTER_B) && in_y)
                    || (y_fetch && (!in_y || win_hit)));
      unimpl = !win_hit && (req_ea > ram_end_r);
      if (!win_hit) begin
         cost = PDM_COST_NONE;
      end else if (rep_active) begin
         cost = (rep_first || rep_last || rep_irq_exit || rep_irq_reentry) ? PDM_COST_TWO : PDM_COST_NONE;
      end else begin
         cost = ((req_mac && req_kind == PDM_K_DATA_RD) || req_move) ? PDM_COST_ONE : PDM_COST_TWO;
      end
      src_nxt = PDM_SRC_NONE;
      if (req_valid) begin
         case (req_kind)
            PDM_K_TBL_RD_LO: src_nxt = PDM_SRC_TBL_LO;
            PDM_K_TBL_RD_HI: src_nxt = PDM_SRC_TBL_HI;
            PDM_K_DATA_RD: begin
               if (wrong_space || unimpl) begin
                  src_nxt = PDM_SRC_ZERO;
               end else if (win_hit) begin
                  src_nxt = PDM_SRC_WIN;
               end else begin
                  src_nxt = PDM_SRC_XRAM;
               end
            end
            default: src_nxt = PDM_SRC_NONE;
         endcase
      end
   end

   // ---------------- Stage 1: address issue ----------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         src_r <= PDM_SRC_NONE;
         ysrc_r <= PDM_SRC_NONE;
         sel_r <= 1'b0;
         byte_r <= 1'b0;
         pm_addr_r <= 24'h000000;
         pm_rd_r <= 1'b0;
      end else begin
         src_r <= y_fetch ? PDM_SRC_NONE : src_nxt;
         ysrc_r <= (is_read && y_fetch) ? (wrong_space || unimpl ? PDM_SRC_ZERO : PDM_SRC_XRAM) : PDM_SRC_NONE;
         sel_r <= req_ea[0];
         byte_r <= req_byte && !req_mac;
         pm_rd_r <= req_valid && !y_fetch && (src_nxt == PDM_SRC_WIN || src_nxt == PDM_SRC_TBL_LO
                    || src_nxt == PDM_SRC_TBL_HI);
         if (req_valid && table_op) begin
            pm_addr_r <= {table_page_r, req_ea};
         end else begin
            pm_addr_r <= {1'b0, program_window_page_r, req_ea[PDM_WIN_LOW_W-1:0]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         x_addr_r <= 16'h0000;
         x_rd_r <= 1'b0;
         x_wr_r <= 1'b0;
         x_byte_r <= 1'b0;
         x_wdata_r <= 16'h0000;
         y_addr_r <= 16'h0000;
         y_rd_r <= 1'b0;
      end else begin
         x_addr_r <= req_ea;
         x_rd_r <= is_read && !y_fetch && (src_nxt == PDM_SRC_XRAM);
         // Writes, write-back included, reach any implemented address outside the window over X only; window writes are dropped.
         x_wr_r <= is_write && !win_hit && !unimpl;
         x_byte_r <= req_byte;
         x_wdata_r <= req_wdata;
         y_addr_r <= req_ea;
         y_rd_r <= is_read && y_fetch && !wrong_space && !unimpl;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         bitrev_en_r <= 1'b0;
         modulo_en_r <= 1'b0;
      end else begin
         bitrev_en_r <= req_bitrev && is_write && !win_hit && !unimpl;
         modulo_en_r <= req_modulo && (is_read || is_write) && !unimpl;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         extra_cycles_r <= PDM_COST_NONE;
         last_win_r <= 1'b0;
         last_zero_r <= 1'b0;
         window_count_r <= 16'h0000;
      end else if (req_valid) begin
         extra_cycles_r <= (is_read || is_write) ? cost : PDM_COST_NONE;
         last_win_r <= (is_read || is_write) && win_hit;
         last_zero_r <= (src_nxt == PDM_SRC_ZERO);
         if ((is_read || is_write) && win_hit) begin
            window_count_r <= window_count_r + 16'h0001;
         end
      end
   end

   // ---------------- Stage 2: return data ----------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_data_r <= 16'h0000;
         y_rd_data_r <= 16'h0000;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= (src_r != PDM_SRC_NONE) || (ysrc_r != PDM_SRC_NONE);
         y_rd_data_r <= (ysrc_r == PDM_SRC_XRAM) ? y_rdata : 16'h0000;
         case (src_r)
            PDM_SRC_XRAM: rd_data_r <= pick_byte(x_rdata, sel_r, byte_r);
            PDM_SRC_WIN: rd_data_r <= pick_byte(pm_rdata[15:0], sel_r, byte_r);
            PDM_SRC_TBL_LO: rd_data_r <= pick_byte(pm_rdata[15:0], sel_r, byte_r);
            PDM_SRC_TBL_HI: begin
               if (byte_r && sel_r) begin
                  rd_data_r <= 16'h0000;
               end else begin
                  rd_data_r <= {8'h00, pm_rdata[23:16]};
               end
            end
            PDM_SRC_ZERO: rd_data_r <= 16'h0000;
            default: rd_data_r <= 16'h0000;
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign pc = pc_r;
   assign pm_addr = pm_addr_r;
   assign pm_rd = pm_rd_r;
   assign x_addr = x_addr_r;
   assign x_rd = x_rd_r;
   assign x_wr = x_wr_r;
   assign x_byte = x_byte_r;
   assign x_wdata = x_wdata_r;
   assign y_addr = y_addr_r;
   assign y_rd = y_rd_r;
   assign bitrev_en = bitrev_en_r;
   assign modulo_en = modulo_en_r;
   assign extra_cycles = extra_cycles_r;
   assign rd_data = rd_data_r;
   assign y_rd_data = y_rd_data_r;
   assign rd_valid = rd_valid_r;

   // ---------------- Assertions ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_PC_STEP: assert property (pc_step && !pc_load |=> pc_r == $past(pc_r) + PDM_PC_STEP)
      else $error("pc did not advance by two");
   AST_TBL_LO_WORD: assert property (req_valid && req_kind == PDM_K_TBL_RD_LO && !req_byte
      |=> ##1 rd_valid_r && rd_data_r == $past(pm_rdata[15:0]))
      else $error("low word table read mismatch");
   AST_TBL_LO_BYTE: assert property (req_valid && req_kind == PDM_K_TBL_RD_LO && req_byte && !req_mac
      && req_ea[0] |=> ##1 rd_data_r == {8'h00, $past(pm_rdata[15:8])})
      else $error("low byte table read mismatch");
   AST_TBL_HI_WORD: assert property (req_valid && req_kind == PDM_K_TBL_RD_HI && !req_byte
      |=> ##1 rd_data_r == {8'h00, $past(pm_rdata[23:16])})
      else $error("high word table read mismatch");
   AST_TBL_HI_ZERO: assert property (req_valid && req_kind == PDM_K_TBL_RD_HI && req_byte && !req_mac
      && req_ea[0] |=> ##1 rd_data_r == 16'h0000)
      else $error("high byte select one not zero");
   AST_WIN_ADDR: assert property (req_valid && req_kind == PDM_K_DATA_RD && req_ea[15]
      && core_control_register_r && !table_busy && !req_mac
      |=> pm_rd_r && pm_addr_r[22:15] == $past(program_window_page_r) && pm_addr_r[14:0] == $past(req_ea[14:0]))
      else $error("window address wrong");
   AST_WIN_OFF: assert property (req_valid && (!core_control_register_r || !req_ea[15]) && !table_op
      |=> !pm_rd_r)
      else $error("window taken without enable");
   AST_TBL_SUSPEND: assert property (req_valid && table_busy && req_kind == PDM_K_DATA_RD |=> !pm_rd_r)
      else $error("window used during table operation");
   AST_COST_OUT: assert property (req_valid && win_hit && !rep_active && req_kind == PDM_K_DATA_WR
      && !req_move |=> extra_cycles_r == PDM_COST_TWO)
      else $error("window cost outside repeat wrong");
   AST_COST_REP: assert property (req_valid && win_hit && rep_active && !rep_first && !rep_last
      && !rep_irq_exit && !rep_irq_reentry && !table_op |=> extra_cycles_r == PDM_COST_NONE)
      else $error("window cost inside repeat wrong");
   AST_Y_NO_WRITE: assert property (y_rd_r |-> $past(req_kind) == PDM_K_DATA_RD && $past(req_mac))
      else $error("Y bus used for something other than an operand read");
   AST_ZERO_RET: assert property (req_valid && req_kind == PDM_K_DATA_RD && req_ea > ram_end_r && !win_hit
      |=> ##1 rd_data_r == 16'h0000 && y_rd_data_r == 16'h0000)
      else $error("invalid access returned data");
   AST_BITREV: assert property (bitrev_en_r |-> $past(req_kind) == PDM_K_DATA_WR)
      else $error("bit reverse on a non-write");
   AST_APB_ONE: assert property (psel && !penable |=> pready_r)
      else $error("apb access not answered");

   COV_WIN_READ: cover property (pm_rd_r && src_r == PDM_SRC_WIN ##1 rd_valid_r);
   COV_MAC_DUAL: cover property (y_rd_r ##1 rd_valid_r && y_rd_data_r != 16'h0000);
   COV_TBL_HI: cover property (src_r == PDM_SRC_TBL_HI ##1 rd_valid_r);
   COV_REP_COST: cover property (rep_active && win_hit && req_valid ##1 extra_cycles_r == PDM_COST_TWO);

endmodule : pdm_mapper

// ---- core/pdm_pkg.sv ----
// Shared constants and types for the program/data space mapper.
// Assumes a single 100 MHz core clock and an APB master with 32-bit data.
package pdm_pkg;
   localparam int PDM_ADDR_W = 8;
   localparam logic [7:0] PDM_OFF_CTRL = 8'h00;
   localparam logic [7:0] PDM_OFF_WPAGE = 8'h04;
   localparam logic [7:0] PDM_OFF_TPAGE = 8'h08;
   localparam logic [7:0] PDM_OFF_YBASE = 8'h0C;
   localparam logic [7:0] PDM_OFF_YEND = 8'h10;
   localparam logic [7:0] PDM_OFF_RAMEND = 8'h14;
   localparam logic [7:0] PDM_OFF_STATUS = 8'h18;
   localparam logic [7:0] PDM_OFF_WINCNT = 8'h1C;
   localparam int PDM_CTRL_WIN_BIT = 0;
   localparam logic [15:0] PDM_YBASE_RST = 16'h0800;
   localparam logic [15:0] PDM_YEND_RST = 16'h0FFF;
   localparam logic [15:0] PDM_RAMEND_RST = 16'h1FFF;
   localparam logic [22:0] PDM_PC_STEP = 23'h000002;
   localparam logic [1:0] PDM_COST_NONE = 2'h0;
   localparam logic [1:0] PDM_COST_ONE = 2'h1;
   localparam logic [1:0] PDM_COST_TWO = 2'h2;
   localparam int PDM_WIN_LOW_W = 15;
   typedef enum logic [2:0] {
      PDM_K_DATA_RD, PDM_K_DATA_WR, PDM_K_TBL_RD_LO, PDM_K_TBL_RD_HI, PDM_K_TBL_WR_LO, PDM_K_TBL_WR_HI
   } pdm_kind_t;
   typedef enum logic [2:0] {
      PDM_P_OTHER, PDM_P_X_POINTER_A, PDM_P_X_POINTER_B, PDM_P_Y_POINTER_A, PDM_P_Y_POINTER_B
   } pdm_ptr_t;
   typedef enum {
      PDM_SRC_NONE, PDM_SRC_ZERO, PDM_SRC_XRAM, PDM_SRC_WIN, PDM_SRC_TBL_LO, PDM_SRC_TBL_HI
   } pdm_src_t;
endpackage : pdm_pkg

// ---- verification/pdm_mapper_tb.sv ----
// Self-checking bench for the program/data space mapper.
// Assumes the memory model answers reads in the strobe cycle.
`timescale 1ns/1ps
module pdm_mapper_tb;
   import pdm_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, g_prd;
   logic pready, pslverr, g_err, pc_step = 1'b0, pc_load = 1'b0;
   logic [22:0] pc_load_value = 23'h0, pc;
   logic req_valid = 1'b0, req_byte = 1'b0, req_mac = 1'b0, req_move = 1'b0, req_bitrev = 1'b0, req_modulo = 1'b0;
   pdm_kind_t req_kind = PDM_K_DATA_RD;
   pdm_ptr_t req_ptr = PDM_P_OTHER;
   logic [15:0] req_ea = 16'h0, req_wdata = 16'h0;
   logic table_busy = 1'b0, rep_active = 1'b0, rep_first = 1'b0, rep_last = 1'b0;
   logic rep_irq_exit = 1'b0, rep_irq_reentry = 1'b0;
   logic [23:0] pm_addr, pm_rdata, s_pa;
   logic pm_rd, x_rd, x_wr, x_byte, y_rd, bitrev_en, modulo_en, rd_valid;
   logic [15:0] x_addr, x_wdata, x_rdata, y_addr, y_rdata, rd_data, y_rd_data, s_xa, s_ya, s_rd, s_yd;
   logic [1:0] extra_cycles, s_ex;
   // Flags seen after a request: pm_rd, x_rd, x_wr, x_byte, y_rd, bitrev_en, modulo_en, rd_valid.
   logic [7:0] s_fl;
   int mismatches = 0, comparisons = 0, cyc = 0;

   pdm_mapper i_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .pc_step, .pc_load, .pc_load_value, .pc, .req_valid, .req_kind, .req_ptr, .req_ea, .req_byte, .req_mac,
      .req_move, .req_bitrev, .req_modulo, .req_wdata, .table_busy, .rep_active, .rep_first, .rep_last,
      .rep_irq_exit, .rep_irq_reentry, .pm_addr, .pm_rd, .pm_rdata, .x_addr, .x_rd, .x_wr, .x_byte, .x_wdata,
      .x_rdata, .y_addr, .y_rd, .y_rdata, .bitrev_en, .modulo_en, .extra_cycles, .rd_data, .y_rd_data, .rd_valid);
   pdm_mem_model i_mem (.clk, .pm_addr, .pm_rd, .pm_rdata, .x_addr, .x_rd, .x_wr, .x_byte, .x_wdata, .x_rdata,
      .y_addr, .y_rd, .y_rdata);

   always #5 clk = ~clk;
   // The whole run needs well under a thousand cycles; a hang ends the run.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   function automatic logic [23:0] pmw(input logic [23:0] a);
      return {a[7:0] ^ 8'hA5, a[15:0] ^ 16'h5A3C};
   endfunction : pmw

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      g_prd = prdata;
      g_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic go(input pdm_kind_t k, input pdm_ptr_t p, input logic [15:0] ea, input logic [4:0] f);
      @(posedge clk);
      req_kind <= k;
      req_ptr <= p;
      req_ea <= ea;
      {req_byte, req_mac, req_move, req_bitrev, req_modulo} <= f;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      s_fl = {pm_rd, x_rd, x_wr, x_byte, y_rd, bitrev_en, modulo_en, 1'b0};
      s_pa = pm_addr;
      s_xa = x_addr;
      s_ya = y_addr;
      s_ex = extra_cycles;
      @(posedge clk);
      #1;
      s_fl[0] = rd_valid;
      s_rd = rd_data;
      s_yd = y_rd_data;
   endtask : go

   task automatic t_regs();
      apb(1'b0, PDM_OFF_YBASE, 32'h0);
      chk(g_prd, {16'h0, PDM_YBASE_RST}, "ybase reset");
      apb(1'b0, PDM_OFF_RAMEND, 32'h0);
      chk(g_prd, {16'h0, PDM_RAMEND_RST}, "ramend reset");
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, g_err}, 32'h1, "unmapped error");
      apb(1'b1, PDM_OFF_WPAGE, 32'h0000_0135);
      apb(1'b0, PDM_OFF_WPAGE, 32'h0);
      chk(g_prd, 32'h35, "page width");
   endtask : t_regs

   task automatic t_table();
      logic [15:0] ea, e;
      logic [23:0] w;
      apb(1'b1, PDM_OFF_TPAGE, 32'h80);
      for (int i = 0; i < 6; i++) begin
         ea = (i % 3 == 2) ? 16'h1235 : 16'h1234;
         w = pmw({8'h80, ea});
         go(i < 3 ? PDM_K_TBL_RD_LO : PDM_K_TBL_RD_HI, PDM_P_OTHER, ea, {i % 3 != 0, 4'h0});
         case (i)
            0: e = w[15:0];
            1: e = {8'h00, w[7:0]};
            2: e = {8'h00, w[15:8]};
            3, 4: e = {8'h00, w[23:16]};
            default: e = 16'h0000;
         endcase
         chk(s_pa, {8'h80, ea}, "table address");
         chk({s_fl[7], s_fl[0]}, 2'b11, "table strobes");
         chk(s_rd, e, "table data");
      end
      go(PDM_K_TBL_WR_LO, PDM_P_OTHER, 16'h1234, 5'b00000);
      chk(s_pa, 24'h801234, "table write address");
      chk(s_fl, 8'h00, "table write strobes");
   endtask : t_table

   task automatic t_data();
      @(posedge clk);
      req_wdata <= 16'h4B2E;
      go(PDM_K_DATA_WR, PDM_P_OTHER, 16'h0812, 5'b00011);
      chk(s_fl, 8'b0010_0110, "write strobes");
      chk(s_xa, 16'h0812, "linear write address");
      chk(x_wdata, 16'h4B2E, "write data");
      go(PDM_K_DATA_RD, PDM_P_OTHER, 16'h0812, 5'b00011);
      chk(s_fl, 8'b0100_0011, "read modes");
      chk(s_rd, 16'h4B2E, "linear read back");
      go(PDM_K_DATA_RD, PDM_P_OTHER, 16'h0011, 5'b10000);
      chk(s_rd, 16'h00D0, "byte read");
      @(posedge clk);
      req_wdata <= 16'h00A7;
      go(PDM_K_DATA_WR, PDM_P_OTHER, 16'h0813, 5'b10000);
      chk(s_fl, 8'b0011_0000, "byte write strobes");
      go(PDM_K_DATA_RD, PDM_P_OTHER, 16'h0812, 5'b00000);
      chk(s_rd, 16'hA72E, "byte write lane");
      go(PDM_K_DATA_RD, PDM_P_Y_POINTER_A, 16'h0820, 5'b01001);
      chk({s_fl[3], s_fl[1], s_ya}, {2'b11, 16'h0820}, "y fetch");
      chk(s_yd, 16'hD010, "y data");
      go(PDM_K_DATA_RD, PDM_P_X_POINTER_B, 16'h0010, 5'b01000);
      chk(s_rd, 16'hD008, "x data");
      go(PDM_K_DATA_RD, PDM_P_X_POINTER_A, 16'h0820, 5'b01000);
      chk(s_rd, 16'h0000, "x pointer into y");
      go(PDM_K_DATA_RD, PDM_P_Y_POINTER_B, 16'h0010, 5'b01000);
      chk(s_yd, 16'h0000, "y pointer into x");
   endtask : t_data

   task automatic t_window();
      logic [23:0] wa, w;
      wa = {1'b0, 8'h35, 15'h0ABC};
      w = pmw(wa);
      apb(1'b1, PDM_OFF_CTRL, 32'h1);
      go(PDM_K_DATA_RD, PDM_P_OTHER, 16'h8ABC, 5'b00000);
      chk(s_pa, wa, "window address");
      chk(s_rd, w[15:0], "window data");
      chk(s_ex, 2'h2, "window cost other");
      go(PDM_K_DATA_RD, PDM_P_OTHER, 16'h8ABC, 5'b00100);
      chk(s_ex, 2'h1, "window cost move");
      go(PDM_K_DATA_RD, PDM_P_X_POINTER_A, 16'h8ABC, 5'b01000);
      chk(s_ex, 2'h1, "window cost prefetch");
      // The window is read-only, so a write there must leave every memory strobe low.
      go(PDM_K_DATA_WR, PDM_P_OTHER, 16'h8ABC, 5'b00000);
      chk(s_fl, 8'h00, "window write dropped");
      chk(s_ex, 2'h2, "window cost write");
      go(PDM_K_TBL_WR_HI, PDM_P_OTHER, 16'h8ABC, 5'b00000);
      chk({s_fl, s_pa}, {8'h00, 24'h808ABC}, "table write hides window");
      // A move inside the loop would cost one outside it, so each flag shows its own effect.
      for (int j = 0; j < 5; j++) begin
         @(posedge clk);
         rep_active <= 1'b1;
         {rep_first, rep_last, rep_irq_exit, rep_irq_reentry} <= 4'b1000 >> j;
         go(PDM_K_DATA_RD, PDM_P_OTHER, 16'h8ABC, 5'b00100);
         chk(s_ex, (j == 4) ? 2'h0 : 2'h2, "repeat cost");
      end
      @(posedge clk);
      rep_active <= 1'b0;
      table_busy <= 1'b1;
      go(PDM_K_DATA_RD, PDM_P_OTHER, 16'h8ABC, 5'b00000);
      chk(s_fl[7], 1'b0, "window hidden by table");
      chk(s_rd, 16'h0000, "unimplemented read");
      @(posedge clk);
      table_busy <= 1'b0;
      apb(1'b1, PDM_OFF_CTRL, 32'h0);
      go(PDM_K_DATA_RD, PDM_P_OTHER, 16'h8ABC, 5'b00000);
      chk(s_fl[7], 1'b0, "window disabled");
      apb(1'b0, PDM_OFF_STATUS, 32'h0);
      chk(g_prd, 32'h8, "status zero return");
      apb(1'b0, PDM_OFF_WINCNT, 32'h0);
      chk(g_prd, 32'h9, "window hit count");
   endtask : t_window

   task automatic t_pc();
      @(posedge clk);
      pc_load <= 1'b1;
      pc_load_value <= 23'h012345;
      @(posedge clk);
      pc_load <= 1'b0;
      pc_step <= 1'b1;
      repeat (2) @(posedge clk);
      pc_step <= 1'b0;
      #1;
      chk(pc, 23'h012348, "program counter step");
   endtask : t_pc

   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_table();
      t_data();
      t_window();
      t_pc();
      finish_test();
   end
endmodule : pdm_mapper_tb

// ---- verification/pdm_mem_model.sv ----
// Program memory and data RAM that stand behind the mapper.
// Assumes read data is wanted in the same cycle as its read strobe.
`timescale 1ns/1ps
module pdm_mem_model (
   input wire logic clk,
   input wire logic [23:0] pm_addr,
   input wire logic pm_rd,
   output logic [23:0] pm_rdata,
   input wire logic [15:0] x_addr,
   input wire logic x_rd,
   input wire logic x_wr,
   input wire logic x_byte,
   input wire logic [15:0] x_wdata,
   output logic [15:0] x_rdata,
   input wire logic [15:0] y_addr,
   input wire logic y_rd,
   output logic [15:0] y_rdata
);
   logic [15:0] ram [0:63];
   logic [23:0] pw;
   // Outside a read every bus shows the inverse, so stale data can never look right.
   assign pw = {pm_addr[7:0] ^ 8'hA5, pm_addr[15:0] ^ 16'h5A3C};
   assign pm_rdata = pm_rd ? pw : ~pw;
   assign x_rdata = x_rd ? ram[x_addr[6:1]] : ~ram[x_addr[6:1]];
   assign y_rdata = y_rd ? ram[y_addr[6:1]] : ~ram[y_addr[6:1]];
   initial begin
      for (int i = 0; i < 64; i++) begin
         ram[i] = 16'hD000 + 16'(i);
      end
   end
   always @(posedge clk) begin
      if (x_wr && !x_byte) begin
         ram[x_addr[6:1]] <= x_wdata;
      end else if (x_wr && x_addr[0]) begin
         ram[x_addr[6:1]][15:8] <= x_wdata[7:0];
      end else if (x_wr) begin
         ram[x_addr[6:1]][7:0] <= x_wdata[7:0];
      end
   end
endmodule : pdm_mem_model
